// *** design/rcs_pkg.sv ***
// Shared constants, carriers and signal-check functions for the receiver
// configuration supervisor.
// Assumes one clock domain and a navigation epoch pulse on that clock.
package rcs_pkg;

  // ==========================================================
  // Sizes and indices
  localparam int NUM_IF = 5;
  localparam int IF_W = 3;
  localparam int NUM_MSG = 4;
  localparam int MSG_W = 2;
  localparam int RATE_WIDTH = 8;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam int NUM_PROTO = 3;
  localparam int PROTO_BIN = 0;
  localparam int PROTO_TEXT = 1;
  localparam int PROTO_CORR = 2;
  localparam int PIO_WIDTH = 32;
  localparam int PIO_SEL_W = 5;
  localparam logic POLL_VERSION = 1'b0;
  localparam logic POLL_RF = 1'b1;

  // Constellation bit positions in the enabled vector
  localparam int NUM_CON = 6;
  localparam int CON_GPS = 0;
  localparam int CON_GAL = 1;
  localparam int CON_BDS = 2;
  localparam int CON_GLO = 3;
  localparam int CON_QZSS = 4;
  localparam int CON_SBAS = 5;

  // ==========================================================
  // Report encodings and text digit counts
  localparam logic [1:0] PWR_OFF = 2'h0;
  localparam logic [1:0] PWR_ON = 2'h1;
  localparam logic [1:0] PWR_UNKNOWN = 2'h2;
  localparam logic [3:0] LAT_HP_DIGITS = 4'h7;
  localparam logic [3:0] ALT_HP_DIGITS = 4'h3;
  localparam logic [3:0] LAT_STD_DIGITS = 4'h5;
  localparam logic [3:0] ALT_STD_DIGITS = 4'h1;

  // ==========================================================
  // Carriers
  typedef enum logic [1:0] {ANT_INIT, ANT_OK, ANT_SHORT, ANT_OPEN} rcs_ant_state_t;

  typedef struct packed {
    logic ena;
    logic b1;
    logic b2;
  } rcs_band_sel_t;

  typedef struct packed {
    rcs_band_sel_t gps;
    rcs_band_sel_t gal;
    rcs_band_sel_t bds;
    rcs_band_sel_t glo;
    rcs_band_sel_t qzss;
    rcs_band_sel_t sbas;
  } rcs_sig_cfg_t;

  typedef struct packed {
    logic volt_ctrl;
    logic short_det;
    logic short_pol;
    logic open_det;
    logic open_pol;
    logic pdown_en;
    logic pdown_pol;
    logic recover_en;
  } rcs_ant_cfg_t;

  typedef struct packed {
    rcs_ant_state_t sup_state;
    logic [1:0] power;
  } rcs_ant_status_t;

  // ==========================================================
  // Signal selection checks
  // enable plus band
  function automatic logic rcs_con_on(rcs_band_sel_t c);
    return c.ena && (c.b1 || c.b2);
  endfunction

  function automatic logic [NUM_CON-1:0] rcs_con_vec(rcs_sig_cfg_t s);
    return {rcs_con_on(s.sbas), rcs_con_on(s.qzss), rcs_con_on(s.glo),
            rcs_con_on(s.bds), rcs_con_on(s.gal), rcs_con_on(s.gps)};
  endfunction

  function automatic logic rcs_sig_valid(rcs_sig_cfg_t s);
    logic [NUM_CON-1:0] on;
    logic ok;
    on = rcs_con_vec(s);
    ok = 1'b1;
    if (on[CON_GAL] && (s.gal.b1 != s.gal.b2)) ok = 1'b0;
    if (on[CON_GLO] && (s.glo.b1 != s.glo.b2)) ok = 1'b0;
    if (on[CON_QZSS] && (s.qzss.b1 != s.qzss.b2)) ok = 1'b0;
    if (on[CON_GPS] && !s.gps.b1) ok = 1'b0;
    if (on[CON_BDS] && !s.bds.b1) ok = 1'b0;
    if (on[CON_QZSS] && !on[CON_GPS]) ok = 1'b0;
    if (on[CON_SBAS] && !(on[CON_GPS] || on[CON_GAL])) ok = 1'b0;
    return ok;
  endfunction

endpackage

// *** design/rcs_pin_sync.sv ***
// Three-stage synchroniser for pins arriving from outside the clock domain.
// A change is accepted only once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module rcs_pin_sync
  import rcs_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // ==========================================================
  // Stage chain; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Per bit agreement filter, rejects one-cycle glitches
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (reset) begin
        pin_out[i] <= RESET_VAL[i];
      end else if (s2_reg[i] == s3_reg[i]) begin
        pin_out[i] <= s3_reg[i];
      end
    end
  end

endmodule
`default_nettype wire

// *** design/rcs_rate_gate.sv ***
// One periodic message slot on one interface: holds its rate and counts
// related events. Assumes epoch is a one-cycle pulse on clk.
`timescale 1ns/100ps
`default_nettype none
module rcs_rate_gate
  import rcs_pkg::*;
#(
  parameter int RATE_W = RATE_WIDTH
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic epoch,
  input wire logic rate_wr,
  input wire logic [RATE_W-1:0] rate_val,
  input wire logic proto_en,
  output logic emit
);

  logic [RATE_W-1:0] rate_reg;
  logic [RATE_W-1:0] count_reg;
  logic due;

  assign due = (rate_reg != '0) && (count_reg >= rate_reg - 1'b1);

  // Stored rate
  always_ff @(posedge clk) begin
    if (reset) begin
      rate_reg <= RATE_W'(RATE_RESET);
    end else if (rate_wr) begin
      rate_reg <= rate_val;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || rate_wr) begin
      count_reg <= '0;
    end else if (epoch && rate_reg != '0) begin
      count_reg <= due ? '0 : count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      emit <= 1'b0;
    end else begin
      emit <= epoch && !rate_wr && due && proto_en;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_zero_rate_silent: assert property (rate_reg == '0 |=> !emit)
    else $error("message emitted with zero rate");
  chk_rate_one_every: assert property (
    epoch && rate_reg == RATE_W'(1) && proto_en && !rate_wr |=> emit)
    else $error("rate one missed an epoch");
  chk_proto_gates_emit: assert property (emit |-> $past(proto_en) && $past(epoch))
    else $error("emit without protocol enable");

endmodule
`default_nettype wire

// *** design/rcs_config_supervisor.sv ***
// Receiver configuration supervisor: message rates per interface, signal
// selection checks, antenna supervision and high-precision text control.
// Assumes config ports come from logic on clk; pio_in and the open sense
// pin are asynchronous pins.
`timescale 1ns/100ps
`default_nettype none

module rcs_config_supervisor
  import rcs_pkg::*;
#(
  parameter int N_IF = NUM_IF,
  parameter int N_MSG = NUM_MSG,
  parameter int PIO_W = PIO_WIDTH
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic epoch,
  input wire logic rate_wr,
  input wire logic [IF_W-1:0] rate_wr_if,
  input wire logic [MSG_W-1:0] rate_wr_msg,
  input wire logic [RATE_WIDTH-1:0] rate_wr_val,
  input wire logic [N_IF*NUM_PROTO-1:0] proto_out_en,
  input wire logic [N_IF-1:0] info_en,
  input wire logic poll_req,
  input wire logic poll_sel,
  input wire logic [IF_W-1:0] poll_if,
  input wire logic sig_wr,
  input wire rcs_sig_cfg_t sig_cfg,
  input wire rcs_ant_cfg_t ant_cfg,
  input wire logic [PIO_SEL_W-1:0] switch_pin_sel,
  input wire logic [PIO_SEL_W-1:0] short_pin_sel,
  input wire logic [PIO_W-1:0] pio_in,
  input wire logic open_sense_pin,
  input wire logic hp_req,
  input wire logic text_compat,
  input wire logic text_limit82,
  output logic [N_IF*N_MSG-1:0] msg_emit,
  output logic [N_IF-1:0] version_emit,
  output logic [N_IF-1:0] rf_report_emit,
  output logic cfg_ack,
  output logic cfg_nak,
  output logic [N_IF-1:0] info_bin_emit,
  output logic [N_IF-1:0] info_txt_emit,
  output logic [NUM_CON-1:0] const_enabled,
  output logic [PIO_W-1:0] pio_out,
  output logic [PIO_W-1:0] pio_oe,
  output rcs_ant_status_t ant_status,
  output logic ant_notice,
  output logic hp_active,
  output logic [3:0] lat_digits,
  output logic [3:0] alt_digits
);

  // ==========================================================
  // Helpers
  // Protocol class of each periodic message slot
  function automatic int msg_proto(int m);
    case (m)
      0, 1: return PROTO_BIN;
      2: return PROTO_TEXT;
      default: return PROTO_CORR;
    endcase
  endfunction

  // Protocol output enable for one interface
  function automatic logic proto_on(logic [N_IF*NUM_PROTO-1:0] en, int i, int p);
    return en[i*NUM_PROTO+p];
  endfunction

  // ==========================================================
  // Periodic message slots
  logic [N_IF*N_MSG-1:0] slot_emit;

  for (genvar i = 0; i < N_IF; i++) begin : g_if
    for (genvar m = 0; m < N_MSG; m++) begin : g_msg
      rcs_rate_gate #(
        .RATE_W(RATE_WIDTH)
      ) u_gate (
        .clk(clk),
        .reset(reset),
        .epoch(epoch),
        .rate_wr(rate_wr && rate_wr_if == IF_W'(i) && rate_wr_msg == MSG_W'(m)),
        .rate_val(rate_wr_val),
        .proto_en(proto_on(proto_out_en, i, msg_proto(m))),
        .emit(slot_emit[i*N_MSG+m])
      );
    end
  end

  // Slot pulses already come from flip-flops; one more stage keeps ports aligned
  always_ff @(posedge clk) begin
    if (reset) begin
      msg_emit <= '0;
    end else begin
      msg_emit <= slot_emit;
    end
  end

  // ==========================================================
  // Polled replies
  // replies only on poll
  always_ff @(posedge clk) begin
    if (reset) begin
      version_emit <= '0;
      rf_report_emit <= '0;
    end else begin
      for (int i = 0; i < N_IF; i++) begin
        version_emit[i] <= poll_req && poll_sel == POLL_VERSION && poll_if == IF_W'(i)
                           && proto_on(proto_out_en, i, PROTO_BIN);
        rf_report_emit[i] <= poll_req && poll_sel == POLL_RF && poll_if == IF_W'(i)
                             && proto_on(proto_out_en, i, PROTO_BIN);
      end
    end
  end

  // ==========================================================
  // Signal selection
  logic sig_ok;
  assign sig_ok = rcs_sig_valid(sig_cfg);

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_ack <= 1'b0;
      cfg_nak <= 1'b0;
    end else begin
      cfg_ack <= sig_wr && sig_ok;
      cfg_nak <= sig_wr && !sig_ok;
    end
  end

  // Refused settings leave the applied selection untouched
  always_ff @(posedge clk) begin
    if (reset) begin
      const_enabled <= '0;
    end else if (sig_wr && sig_ok) begin
      const_enabled <= rcs_con_vec(sig_cfg);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      info_bin_emit <= '0;
      info_txt_emit <= '0;
    end else begin
      for (int i = 0; i < N_IF; i++) begin
        info_bin_emit[i] <= sig_wr && !sig_ok && info_en[i] && proto_on(proto_out_en, i, PROTO_BIN);
        info_txt_emit[i] <= sig_wr && !sig_ok && info_en[i] && proto_on(proto_out_en, i, PROTO_TEXT);
      end
    end
  end

  // ==========================================================
  // Antenna sense pins
  logic [PIO_W:0] sense_sync;
  logic short_pin;
  logic open_pin;
  logic short_act;
  logic open_act;

  // Idle level high suits the active-low default
  rcs_pin_sync #(
    .WIDTH(PIO_W+1),
    .RESET_VAL('1)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .pin_in({open_sense_pin, pio_in}),
    .pin_out(sense_sync)
  );

  assign short_pin = sense_sync[short_pin_sel];
  assign open_pin = sense_sync[PIO_W];

  assign short_act = ant_cfg.short_det && (ant_cfg.short_pol ? !short_pin : short_pin);
  assign open_act = ant_cfg.open_det && (ant_cfg.open_pol ? !open_pin : open_pin);

  // ==========================================================
  // Supply cut and recovery
  logic cut_reg;
  logic cut_allowed;
  logic recover_ok;

  assign cut_allowed = ant_cfg.pdown_en && ant_cfg.volt_ctrl && ant_cfg.short_det;
  assign recover_ok = ant_cfg.recover_en && ant_cfg.short_det && ant_cfg.pdown_en;

  // Without recovery a cut holds until pdown_en or volt_ctrl is cleared; clearing short_det alone keeps it
  always_ff @(posedge clk) begin
    if (reset) begin
      cut_reg <= 1'b0;
    end else if (!cut_allowed && !(ant_cfg.pdown_en && ant_cfg.volt_ctrl)) begin
      cut_reg <= 1'b0;
    end else if (short_act && cut_allowed) begin
      cut_reg <= 1'b1;
    end else if (!short_act && recover_ok) begin
      cut_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pio_out <= '0;
      pio_oe <= '0;
    end else begin
      for (int i = 0; i < PIO_W; i++) begin
        pio_oe[i] <= ant_cfg.volt_ctrl && switch_pin_sel == PIO_SEL_W'(i);
        pio_out[i] <= switch_pin_sel == PIO_SEL_W'(i) && (ant_cfg.pdown_pol ? cut_reg : !cut_reg);
      end
    end
  end

  // ==========================================================
  // Supervisor status and notices
  rcs_ant_state_t state_next;
  logic [1:0] power_next;

  // Short outranks open: a shorted feed also looks loaded
  always_comb begin
    case (1'b1)
      short_act: state_next = ANT_SHORT;
      open_act: state_next = ANT_OPEN;
      default: state_next = ANT_OK;
    endcase
  end

  always_comb begin
    if (!ant_cfg.volt_ctrl) begin
      power_next = PWR_UNKNOWN;
    end else if (cut_reg) begin
      power_next = PWR_OFF;
    end else begin
      power_next = PWR_ON;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ant_status <= '{sup_state: ANT_INIT, power: PWR_UNKNOWN};
      ant_notice <= 1'b0;
    end else begin
      ant_status <= '{sup_state: state_next, power: power_next};
      ant_notice <= (ant_status.sup_state != state_next) || (ant_status.power != power_next);
    end
  end

  // ==========================================================
  // High-precision text mode
  // off at reset, barred
  always_ff @(posedge clk) begin
    if (reset) begin
      hp_active <= 1'b0;
    end else begin
      hp_active <= hp_req && !text_compat && !text_limit82;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lat_digits <= LAT_STD_DIGITS;
      alt_digits <= ALT_STD_DIGITS;
    end else begin
      lat_digits <= (hp_req && !text_compat && !text_limit82) ? LAT_HP_DIGITS : LAT_STD_DIGITS;
      alt_digits <= (hp_req && !text_compat && !text_limit82) ? ALT_HP_DIGITS : ALT_STD_DIGITS;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_good_write;
    sig_wr && sig_ok;
  endsequence

  sequence s_ack_applied;
    cfg_ack && !cfg_nak && const_enabled == rcs_con_vec($past(sig_cfg));
  endsequence

  chk_ack_applies_cfg: assert property (s_good_write |=> s_ack_applied)
    else $error("accepted settings not applied");
  chk_nak_on_bad: assert property (sig_wr && !sig_ok |=> cfg_nak && !cfg_ack)
    else $error("bad settings not refused");
  chk_regional_needs_gps: assert property (const_enabled[CON_QZSS] |-> const_enabled[CON_GPS])
    else $error("regional constellation without GPS");
  chk_sbas_needs_base: assert property (
    const_enabled[CON_SBAS] |-> const_enabled[CON_GPS] || const_enabled[CON_GAL])
    else $error("augmentation without GPS or Galileo");
  chk_cut_needs_enables: assert property ($rose(cut_reg) |-> $past(cut_allowed && short_act))
    else $error("supply cut without enables");
  chk_no_auto_recover: assert property (
    cut_reg && !ant_cfg.recover_en && ant_cfg.pdown_en && ant_cfg.volt_ctrl |=> cut_reg)
    else $error("supply restored without recovery");
  chk_notice_on_change: assert property (!$stable(ant_status) |-> ant_notice)
    else $error("status change without notice");
  chk_version_poll_only: assert property (
    version_emit != '0 |-> $past(poll_req && poll_sel == POLL_VERSION))
    else $error("version report without poll");
  chk_hp_blocked: assert property (text_compat || text_limit82 |=> !hp_active && lat_digits == LAT_STD_DIGITS)
    else $error("high precision while barred");
  chk_hp_digits: assert property (hp_active |-> lat_digits == 4'h7 && alt_digits == 4'h3)
    else $error("wrong high precision digits");

endmodule
`default_nettype wire

// *** tb/rcs_ant_model.sv ***
// Active antenna model: drives the short sense pin and the open sense pin.
// Assumes the supervisor samples both pins through its own synchroniser.
`timescale 1ns/100ps
`default_nettype none
module rcs_ant_model
  import rcs_pkg::*;
(
  input wire logic clk,
  input wire logic short_fault,
  input wire logic open_fault,
  input wire logic short_pol,
  input wire logic open_pol,
  input wire logic [PIO_SEL_W-1:0] short_sel,
  output logic [PIO_WIDTH-1:0] pio_in,
  output logic open_sense_pin
);
  // ==========================================
  // Unused pins and sense levels
  logic [PIO_WIDTH-1:0] noise_reg;
  // Other pins carry a pattern that shifts every cycle so a wrong pin select shows up
  initial noise_reg = 32'h5a3c96e1;
  always @(posedge clk) noise_reg <= {noise_reg[30:0], noise_reg[31] ^ noise_reg[21]};
  always_comb begin
    pio_in = noise_reg;
    pio_in[short_sel] = short_fault ^ short_pol;
    open_sense_pin = open_fault ^ open_pol;
  end
endmodule
`default_nettype wire

// *** tb/tb_rcs_config_supervisor.sv ***
// Self-checking bench for the receiver configuration supervisor.
// Assumes the antenna model stands on the sense pins.
`timescale 1ns/100ps
`default_nettype none
module tb_rcs_config_supervisor;
  import rcs_pkg::*;
  // ==========================================
  // Signals
  logic clk, reset, epoch, rate_wr, poll_req, poll_sel, sig_wr, hp_req, text_compat, text_limit82;
  logic open_sense_pin, cfg_ack, cfg_nak, ant_notice, hp_active, short_fault, open_fault, notice_seen;
  logic [2:0] rate_wr_if, poll_if;
  logic [1:0] rate_wr_msg;
  logic [7:0] rate_wr_val;
  logic [14:0] proto_out_en;
  logic [4:0] info_en, switch_pin_sel, short_pin_sel, version_emit, rf_report_emit, info_bin_emit, info_txt_emit;
  logic [19:0] msg_emit;
  logic [31:0] pio_in, pio_out, pio_oe, seed;
  logic [5:0] const_enabled, con_m;
  logic [3:0] lat_digits, alt_digits;
  logic [41:0] pulses;
  logic [41:0] exp_q[$];
  rcs_sig_cfg_t sig_cfg;
  rcs_ant_cfg_t ant_cfg;
  rcs_ant_status_t ant_status;
  int rate_m[20], cnt_m[20];
  int n_errors, checked;
  logic [17:0] sc[8] = '{18'h37c3e, 18'h36000, 18'h07038, 18'h07006, 18'h00006, 18'h28000, 18'h040c0, 18'h00fc0};
  logic [7:0] sok = 8'hc9;
  logic [5:0] scv[8] = '{6'h37, 6'h37, 6'h37, 6'h22, 6'h22, 6'h22, 6'h00, 6'h0c};

  rcs_config_supervisor uut (.clk(clk), .reset(reset), .epoch(epoch), .rate_wr(rate_wr),
    .rate_wr_if(rate_wr_if), .rate_wr_msg(rate_wr_msg), .rate_wr_val(rate_wr_val),
    .proto_out_en(proto_out_en), .info_en(info_en), .poll_req(poll_req), .poll_sel(poll_sel),
    .poll_if(poll_if), .sig_wr(sig_wr), .sig_cfg(sig_cfg), .ant_cfg(ant_cfg),
    .switch_pin_sel(switch_pin_sel), .short_pin_sel(short_pin_sel), .pio_in(pio_in),
    .open_sense_pin(open_sense_pin), .hp_req(hp_req), .text_compat(text_compat),
    .text_limit82(text_limit82), .msg_emit(msg_emit), .version_emit(version_emit),
    .rf_report_emit(rf_report_emit), .cfg_ack(cfg_ack), .cfg_nak(cfg_nak),
    .info_bin_emit(info_bin_emit), .info_txt_emit(info_txt_emit), .const_enabled(const_enabled),
    .pio_out(pio_out), .pio_oe(pio_oe), .ant_status(ant_status), .ant_notice(ant_notice),
    .hp_active(hp_active), .lat_digits(lat_digits), .alt_digits(alt_digits));
  rcs_ant_model u_ant (.clk(clk), .short_fault(short_fault), .open_fault(open_fault),
    .short_pol(ant_cfg.short_pol), .open_pol(ant_cfg.open_pol), .short_sel(short_pin_sel),
    .pio_in(pio_in), .open_sense_pin(open_sense_pin));

  // ==========================================
  // Clock, pulse monitor and helpers
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  assign pulses = {msg_emit, version_emit, rf_report_emit, cfg_ack, cfg_nak, info_bin_emit, info_txt_emit};
  // Falling edge sees each one-cycle pulse once, fully settled
  always @(negedge clk) begin
    if (ant_notice === 1'b1) notice_seen = 1'b1;
    if (pulses !== 42'h0) cmp_pulse(pulses);
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp_lvl(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pulse(input logic [41:0] got);
    logic [41:0] exp;
    exp = (exp_q.size() > 0) ? exp_q.pop_front() : 42'h0;
    cmp_lvl({22'h0, got}, {22'h0, exp});
  endtask
  task automatic end_sim();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ==========================================
  // Drivers with expectation notes
  task automatic wr_rate(input int i, input int m, input int v);
    @(posedge clk);
    rate_wr <= 1'b1;
    rate_wr_if <= 3'(i);
    rate_wr_msg <= 2'(m);
    rate_wr_val <= 8'(v);
    rate_m[i*4+m] = v;
    cnt_m[i*4+m] = 0;
    @(posedge clk);
    rate_wr <= 1'b0;
  endtask
  task automatic do_epoch();
    logic [19:0] m;
    m = 20'h0;
    @(posedge clk);
    epoch <= 1'b1;
    for (int s = 0; s < 20; s++) begin
      if (rate_m[s] != 0) begin
        cnt_m[s]++;
        if (cnt_m[s] == rate_m[s]) begin
          cnt_m[s] = 0;
          m[s] = proto_out_en[(s/4)*3 + ((s%4) < 2 ? 0 : (s%4) - 1)];
        end
      end
    end
    if (m != 20'h0) exp_q.push_back({m, 22'h0});
    @(posedge clk);
    epoch <= 1'b0;
    tick(3);
  endtask
  // poll answered where binary is on
  task automatic poll(input int i, input logic s);
    @(posedge clk);
    poll_req <= 1'b1;
    poll_if <= 3'(i);
    poll_sel <= s;
    if (proto_out_en[i*3]) exp_q.push_back(42'h1 << ((s ? 12 : 17) + i));
    @(posedge clk);
    poll_req <= 1'b0;
    tick(2);
  endtask
  task automatic sig_write(input int k);
    logic [4:0] ib, it;
    // Read enables after the edge so freshly scheduled values are seen
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      ib[i] = info_en[i] & proto_out_en[i*3];
      it[i] = info_en[i] & proto_out_en[i*3+1];
    end
    sig_wr <= 1'b1;
    sig_cfg <= sc[k];
    exp_q.push_back(sok[k] ? 42'h800 : {31'h1, ib, it});
    @(posedge clk);
    sig_wr <= 1'b0;
    tick(2);
    cmp_lvl(const_enabled, scv[k]);
  endtask
  task automatic ant_step(input logic sf, input logic of, input rcs_ant_state_t st, input logic [1:0] pw,
                          input logic pin, input logic nt);
    int k;
    @(posedge clk);
    short_fault <= sf;
    open_fault <= of;
    notice_seen = 1'b0;
    k = 0;
    while (ant_status.sup_state !== st && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (ant_status.sup_state !== st) begin
      n_errors++;
      end_sim();
    end
    tick(3);
    cmp_lvl(ant_status, {st, pw});
    cmp_lvl(pio_out, {24'h0, pin, 7'h0});
    cmp_lvl(notice_seen, nt);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end
  initial begin
    seed = 32'hdecf2a44;
    {reset, epoch, rate_wr, poll_req, poll_sel, sig_wr, hp_req, text_compat, text_limit82} = 9'h100;
    {rate_wr_if, poll_if, rate_wr_msg, rate_wr_val, short_fault, open_fault} = 18'h0;
    {proto_out_en, info_en, sig_cfg} = {15'h7fff, 5'h1f, 18'h0};
    {ant_cfg, switch_pin_sel, short_pin_sel} = {8'hff, 5'h07, 5'h03};
    for (int s = 0; s < 20; s++) {rate_m[s], cnt_m[s]} = 64'h0;
    tick(2);
    @(negedge clk);
    cmp_lvl({ant_status, const_enabled, hp_active, lat_digits, alt_digits}, {ANT_INIT, PWR_UNKNOWN, 15'h51});
    @(posedge clk);
    reset <= 1'b0;
    wr_rate(0, 0, 1);
    wr_rate(0, 1, 2);
    wr_rate(1, 2, 0);
    wr_rate(2, 3, 1 + xs() % 4);
    wr_rate(3, 0, 3);
    wr_rate(4, 1, 1);
    repeat (5) do_epoch();
    wr_rate(0, 1, 2);
    proto_out_en <= 15'h7ffe;
    repeat (5) do_epoch();
    proto_out_en <= 15'h6fff;
    for (int i = 0; i < 5; i++) begin
      poll(i, POLL_VERSION);
      poll(i, POLL_RF);
    end
    proto_out_en <= 15'h7fef;
    info_en <= 5'(xs());
    for (int k = 0; k < 8; k++) sig_write(k);
    ant_step(1'b0, 1'b0, ANT_OK, PWR_ON, 1'b0, 1'b0);
    cmp_lvl(pio_oe, 32'h80);
    ant_step(1'b1, 1'b0, ANT_SHORT, PWR_OFF, 1'b1, 1'b1);
    ant_step(1'b0, 1'b0, ANT_OK, PWR_ON, 1'b0, 1'b1);
    ant_step(1'b0, 1'b1, ANT_OPEN, PWR_ON, 1'b0, 1'b1);
    ant_step(1'b0, 1'b0, ANT_OK, PWR_ON, 1'b0, 1'b1);
    // Active-high short sense, active-low open sense, active-low switch, no auto recovery
    // Short detect off while the sense pin settles, else a stale level trips a cut
    ant_cfg <= 8'h9c;
    tick(8);
    ant_cfg <= 8'hdc;
    tick(8);
    cmp_lvl(pio_out, 32'h80);
    ant_step(1'b1, 1'b0, ANT_SHORT, PWR_OFF, 1'b0, 1'b1);
    ant_step(1'b0, 1'b0, ANT_OK, PWR_OFF, 1'b0, 1'b1);
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      {hp_req, text_compat, text_limit82} <= 3'(c);
      tick(2);
      cmp_lvl({hp_active, lat_digits, alt_digits}, (c == 4) ? 9'h173 : 9'h051);
    end
    tick(4);
    cmp_lvl(exp_q.size(), 0);
    end_sim();
  end
endmodule
`default_nettype wire
